// ---- design/mwfc_pkg.sv ----
package mwfc_pkg;
  localparam int MW_W = 88;
  localparam int CS_DEPTH_DEF = 1000;
  localparam int UA_W = 10;
  // field positions (low bit) within the microword
  localparam int F_NEXT = 76;
  localparam int F_A_SIDE_REGISTER_SELECT = 72;
  localparam int F_SPW = 70;
  localparam int F_CARRY = 69;
  localparam int F_B_SIDE_REGISTER_SELECT = 65;
  localparam int F_SHFIN = 64;
  localparam int F_SHDIR = 62;
  localparam int F_DST = 59;
  localparam int F_FN = 56;
  localparam int F_SRC = 53;
  localparam int F_DSRC = 52;
  localparam int F_INPUT_MUX_DRIVE_ENABLE = 51;
  localparam int F_SWAP = 49;
  localparam int F_YEN = 48;
  localparam int F_HOE = 47;
  localparam int F_CCPOS = 46;
  localparam int F_BSEL = 41;
  localparam int F_CONST = 38;
  localparam int F_SGNIN = 37;
  localparam int F_SGNOUT = 36;
  localparam int F_BCD_SHIFT_SOURCE_SELECT = 34;
  localparam int F_DECIMAL_OPERATION_CONTROL = 32;
  localparam int F_HNIB = 30;
  localparam int F_LNIB = 28;
  localparam int F_BEN = 25;
  localparam int F_ODD = 21;
  localparam int F_OPEN = 16;
  localparam int F_HUA = 10;
  localparam int F_CCBR = 6;
  localparam int F_ARBR = 2;
  localparam int F_MODE = 1;
  localparam int F_DCB = 0;
  // idle microword with every field at its default
  localparam logic [87:0] MW_RESET = {12'h000, 4'hf, 2'h0, 1'h1, 4'hf, 1'h0, 2'h0, 3'h3, 3'h3, 3'h7,
    1'h0, 1'h0, 2'h0, 1'h1, 1'h0, 1'h0, 5'h00, 3'h0, 1'h0, 1'h0, 2'h0, 2'h0, 2'h0, 2'h0, 3'h0,
    4'h0, 5'h00, 6'h01, 4'h0, 4'h0, 1'h0, 1'h0};
  localparam logic [9:0] IDLE_UA = 10'h000;
  localparam logic [6:0] EXT_OPC_TOP = 7'h3e;
  localparam logic [9:0] ENTRY_BASE = 10'h060;
  localparam logic [8:0] HUA_BASE = 9'h1e0;
  localparam logic [8:0] HUA_MAX = 9'h1fe;
  localparam logic [1:0] SPW_NONE = 2'h0;
  localparam logic [1:0] SPW_BOTH = 2'h1;
  localparam logic [1:0] SPW_LOW = 2'h2;
  localparam logic [1:0] SPW_FILE = 2'h3;
  localparam logic [15:0] CONST_ROM [8] = '{16'h0007, 16'h0001, 16'h0002, 16'h0003,
    16'h0004, 16'h0005, 16'h0006, 16'h0008};
  // register port map
  localparam logic [7:0] REG_CS_INDEX = 8'h00;
  localparam logic [7:0] REG_CS_DATA0 = 8'h04;
  localparam logic [7:0] REG_CS_DATA1 = 8'h08;
  localparam logic [7:0] REG_CS_DATA2 = 8'h0c;
  localparam logic [7:0] REG_CTRL = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  typedef enum {MWFC_HALT, MWFC_IDLE, MWFC_RUN} mwfc_seq_t;
endpackage : mwfc_pkg

// ---- design/mwfc_field_if.sv ----
`timescale 1ns/1ps
interface mwfc_field_if;
  logic [87:0] mw;
  logic sp_wr_hi;
  logic sp_wr_lo;
  logic [7:0] bus_en;
  logic [6:0] op_en;
  logic [8:0] host_ua;
  logic [15:0] const_val;
  modport dec (input mw, output sp_wr_hi, sp_wr_lo, bus_en, op_en, host_ua, const_val);
  modport top (output mw, input sp_wr_hi, sp_wr_lo, bus_en, op_en, host_ua, const_val);
endinterface : mwfc_field_if

// ---- design/mwfc_field_decode.sv ----
`timescale 1ns/1ps
module mwfc_field_decode (
  mwfc_field_if.dec f
);
  import mwfc_pkg::*;

  // one-hot decode with zero meaning none
  function automatic logic [7:0] mwfc_onehot(input logic [2:0] v);
    mwfc_onehot = (v == 3'h0) ? 8'h00 : (8'h01 << v);
  endfunction : mwfc_onehot

  logic [1:0] register_file_write;
  logic [4:0] bsel;
  logic [2:0] ben;
  logic [4:0] open;
  logic [5:0] hua;
  logic [7:0] op_oh;
  assign register_file_write = f.mw[F_SPW +: 2];
  assign bsel = f.mw[F_BSEL +: 5];
  assign ben = f.mw[F_BEN +: 3];
  assign open = f.mw[F_OPEN +: 5];
  assign hua = f.mw[F_HUA +: 6];
  assign op_oh = (open[4:3] == 2'h0) ? mwfc_onehot(open[2:0]) : 8'h00;

  // scratch-pad byte gates, zero blocks every write
  assign f.sp_wr_hi = (register_file_write == SPW_BOTH) || (register_file_write == SPW_FILE); // [RL6] [RL22]
  assign f.sp_wr_lo = (register_file_write != SPW_NONE); // [RL6] [RL22]
  // bus sources need both select fields nonzero
  assign f.bus_en = (bsel == 5'h00) ? 8'h00 : mwfc_onehot(ben); // [RL15]
  // seven operation enables, value 0 enables none
  assign f.op_en = op_oh[7:1]; // [RL18]
  // host micro-address, saturated at the top of its range
  assign f.host_ua = ({3'h0, hua} > (HUA_MAX - HUA_BASE)) ? HUA_MAX : (HUA_BASE + {3'h0, hua}); // [RL19]
  assign f.const_val = CONST_ROM[f.mw[F_CONST +: 3]]; // [RL16]
endmodule : mwfc_field_decode

// ---- design/mwfc_microword_control.sv ----
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// [RL1] control store holds 1000 words of 88 bits; each commands datapath and next address
// [RL2] a valid 076nnn opcode jumps to its decoded entry word; device takes control
// [RL3] routine end returns to idle address 0, hands back, keeps watching host lines
// [RL4] bits 87:76 give next address, modified by branch tests and condition codes
// [RL5] bits 75:72 and 68:65 pick A and B registers, default 17 octal
// [RL6] bits 71:70 gate byte or word register writes; zero disables writing
// [RL7] bit 69 is carry inject, 1 meaning no carry
// [RL8] bit 64 is shift fill value; bits 63:62 shift direction, 0 left RAM
// [RL9] bits 61:59 select ALU destination, default 3 result to Y and B
// [RL10] bits 58:56 select ALU function, default 3 is OR
// [RL11] bits 55:53 select ALU operands, default 7 direct data and zero
// [RL12] bit 52 direct source, bit 51 input mux enable, bits 50:49 byte swap
// [RL13] bit 48 enables Y outputs, bit 47 drives internal bus onto host lines
// [RL14] bit 46 picks condition-code byte, 0 high byte
// [RL15] bits 45:41 with 27:25 give eight bus-source enables; zero drives nothing (here 27:25 at zero also drives nothing, so enable bit 0 is never set)
// [RL16] bits 40:38 pick one of eight constants, 0 gives 7
// [RL17] bits 37,36 enable sign translation; bits 35:28 steer the decimal datapath
// [RL18] bits 24:21 odd-address latch enables, 20:16 decode seven operation enables
// [RL19] bits 15:10 decode to host micro-address 740 to 776 octal, default 741
// [RL20] bits 9:6 branch low three bits on codes, 5:2 branch low eight
// [RL21] bit 1 is mode, 1 means device controls; bit 0 puts decimal carry on bus
// [RL22] write field codes: 0 none, 1 both bytes, 2 low byte, 3 register file
// [RL23] addressed microword is registered once per clock
module mwfc_microword_control #(
  parameter int CS_DEPTH = mwfc_pkg::CS_DEPTH_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [15:0] host_shared_lines_in,
  output logic [15:0] host_shared_lines_out,
  output logic host_shared_lines_oe,
  input wire logic [15:0] internal_data_bus_in,
  input wire logic [3:0] cond_codes_in,
  input wire logic [7:0] branch_array_in,
  output logic [9:0] microaddress,
  output logic coprocessor_mode_bit,
  output logic [3:0] a_side_register_select,
  output logic [3:0] b_side_register_select,
  output logic sp_write_high,
  output logic sp_write_low,
  output logic binary_carry_inject,
  output logic shift_fill_value,
  output logic [1:0] shift_direction_control,
  output logic [2:0] binary_destination_select,
  output logic [2:0] binary_function_select,
  output logic [2:0] binary_operand_select,
  output logic direct_input_source_select,
  output logic input_mux_drive_enable,
  output logic [1:0] byte_swap_control,
  output logic y_output_buffer_enable,
  output logic cc_byte_position,
  output logic [7:0] bus_source_enables,
  output logic [15:0] constant_value,
  output logic input_sign_translate,
  output logic output_sign_translate,
  output logic [1:0] bcd_shift_source_select,
  output logic [1:0] decimal_operation_control,
  output logic [1:0] high_nibble_path_select,
  output logic [1:0] low_nibble_path_select,
  output logic [3:0] odd_address_latch_enables,
  output logic [6:0] operation_enables,
  output logic [8:0] host_microaddress,
  output logic decimal_carry_to_bus
);
  import mwfc_pkg::*;

  typedef struct packed {
    logic [CS_DEPTH-1:0][87:0] cs;
    logic [87:0] mw;
    logic [9:0] ua;
    mwfc_seq_t seq;
    logic [9:0] cs_index;
    logic [63:0] stage;
    logic run;
    logic [31:0] rdata;
    logic sp_hi;
    logic sp_lo;
    logic [7:0] bus_en;
    logic [6:0] op_en;
    logic [8:0] host_ua;
    logic [15:0] const_val;
    logic [15:0] host_out;
    logic host_oe;
    logic dispatched;
    logic carry_inj;
  } mwfc_state_t;

  mwfc_state_t s_reg;
  mwfc_state_t s_next;
  mwfc_field_if fld ();

  // next address field with both branch sources merged in
  function automatic logic [9:0] mwfc_branch(input logic [87:0] w, input logic [3:0] cc,
                                             input logic [7:0] arr);
    logic [9:0] a;
    logic [3:0] ccsel;
    logic [3:0] arsel;
    a = w[F_NEXT +: 10];
    ccsel = w[F_CCBR +: 4];
    arsel = w[F_ARBR +: 4];
    // condition-code test ORs into the low three bits
    if (ccsel != 4'h0) begin
      a[2:0] = a[2:0] | (cc[ccsel[1:0]] ? {ccsel[3:2], 1'h1} : 3'h0); // [RL20] [RL4]
    end
    // logic-array branch ORs into the low eight bits
    if (arsel != 4'h0) begin
      a[7:0] = a[7:0] | arr; // [RL20] [RL4]
    end
    mwfc_branch = a;
  endfunction : mwfc_branch

  // extended opcode check on the host lines
  function automatic logic mwfc_opc_valid(input logic [15:0] op);
    mwfc_opc_valid = (op[15:9] == EXT_OPC_TOP) && (op[8:6] == 3'h0);
  endfunction : mwfc_opc_valid

  logic [9:0] branch_ua;
  logic [9:0] target_ua;
  logic [87:0] target_mw;
  assign branch_ua = mwfc_branch(s_reg.mw, cond_codes_in, branch_array_in);

  // choose the following control-store address
  always_comb begin
    target_ua = branch_ua;
    if (s_reg.seq == MWFC_IDLE) begin
      if (mwfc_opc_valid(host_shared_lines_in)) begin
        target_ua = ENTRY_BASE + {4'h0, host_shared_lines_in[5:0]}; // [RL2]
      end else begin
        target_ua = IDLE_UA; // [RL3]
      end
    end
    if ({22'h0, target_ua} < CS_DEPTH) begin
      target_mw = s_reg.cs[target_ua]; // [RL1]
    end else begin
      target_mw = MW_RESET;
    end
  end

  // decoder sees the word about to load, formed apart from the state process to avoid a loop
  assign fld.mw = (s_reg.seq == MWFC_HALT) ? MW_RESET : target_mw;
  mwfc_field_decode u_decode (
    .f(fld.dec)
  );

  // whole next-state computation
  always_comb begin
    s_next = s_reg;
    s_next.dispatched = 1'h0;
    s_next.rdata = 32'h0;
    case (s_reg.seq)
      MWFC_HALT: begin
        s_next.mw = MW_RESET;
        s_next.ua = IDLE_UA;
        if (s_reg.run) begin
          s_next.seq = MWFC_IDLE;
        end
      end
      MWFC_IDLE: begin
        s_next.mw = target_mw; // [RL23]
        s_next.ua = target_ua;
        if (!s_reg.run) begin
          s_next.seq = MWFC_HALT;
        end else if (target_ua != IDLE_UA) begin
          s_next.seq = MWFC_RUN; // [RL2]
          s_next.dispatched = 1'h1;
        end
      end
      MWFC_RUN: begin
        s_next.mw = target_mw; // [RL23] [RL4]
        s_next.ua = target_ua;
        if (target_ua == IDLE_UA) begin
          s_next.seq = MWFC_IDLE; // [RL3]
        end
      end
      default: begin
        s_next.seq = MWFC_HALT;
      end
    endcase
    // registered decodes of the word being loaded
    s_next.sp_hi = fld.sp_wr_hi; // [RL6]
    s_next.sp_lo = fld.sp_wr_lo; // [RL6]
    s_next.bus_en = fld.bus_en; // [RL15]
    s_next.op_en = fld.op_en; // [RL18]
    s_next.host_ua = fld.host_ua; // [RL19]
    s_next.const_val = fld.const_val; // [RL16]
    s_next.host_oe = s_next.mw[F_HOE]; // [RL13]
    s_next.carry_inj = ~s_next.mw[F_CARRY]; // [RL7]
    s_next.host_out = internal_data_bus_in;
    // register writes
    if (reg_wr) begin
      case (reg_addr)
        REG_CS_INDEX: s_next.cs_index = reg_wdata[9:0];
        REG_CS_DATA0: s_next.stage[31:0] = reg_wdata;
        REG_CS_DATA1: s_next.stage[63:32] = reg_wdata;
        REG_CS_DATA2: begin
          if ({22'h0, s_reg.cs_index} < CS_DEPTH) begin
            s_next.cs[s_reg.cs_index] = {reg_wdata[23:0], s_reg.stage}; // [RL1]
          end
          s_next.cs_index = s_reg.cs_index + 10'h001;
        end
        REG_CTRL: s_next.run = reg_wdata[0];
        default: begin
        end
      endcase
    end
    // register reads, answered in the following cycle
    if (reg_rd) begin
      case (reg_addr)
        REG_CS_INDEX: s_next.rdata = {22'h0, s_reg.cs_index};
        REG_CS_DATA0: s_next.rdata = s_reg.stage[31:0];
        REG_CS_DATA1: s_next.rdata = s_reg.stage[63:32];
        REG_CTRL: s_next.rdata = {31'h0, s_reg.run};
        REG_STATUS: s_next.rdata = {6'h0, s_reg.ua, 13'h0, (s_reg.seq == MWFC_IDLE),
                                    s_reg.mw[F_MODE], s_reg.run};
        default: s_next.rdata = 32'h0;
      endcase
    end
  end

  // single state register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.mw <= MW_RESET;
      s_reg.seq <= MWFC_HALT;
      s_reg.host_ua <= HUA_BASE + 9'h001;
      s_reg.const_val <= CONST_ROM[0];
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs are flop bits or slices of the registered word
  assign reg_rdata = s_reg.rdata;
  assign microaddress = s_reg.ua;
  assign coprocessor_mode_bit = s_reg.mw[F_MODE]; // [RL21]
  assign a_side_register_select = s_reg.mw[F_A_SIDE_REGISTER_SELECT +: 4]; // [RL5]
  assign b_side_register_select = s_reg.mw[F_B_SIDE_REGISTER_SELECT +: 4]; // [RL5]
  assign sp_write_high = s_reg.sp_hi;
  assign sp_write_low = s_reg.sp_lo;
  assign binary_carry_inject = s_reg.carry_inj; // [RL7]
  assign shift_fill_value = s_reg.mw[F_SHFIN]; // [RL8]
  assign shift_direction_control = s_reg.mw[F_SHDIR +: 2]; // [RL8]
  assign binary_destination_select = s_reg.mw[F_DST +: 3]; // [RL9]
  assign binary_function_select = s_reg.mw[F_FN +: 3]; // [RL10]
  assign binary_operand_select = s_reg.mw[F_SRC +: 3]; // [RL11]
  assign direct_input_source_select = s_reg.mw[F_DSRC]; // [RL12]
  assign input_mux_drive_enable = s_reg.mw[F_INPUT_MUX_DRIVE_ENABLE]; // [RL12]
  assign byte_swap_control = s_reg.mw[F_SWAP +: 2]; // [RL12]
  assign y_output_buffer_enable = s_reg.mw[F_YEN]; // [RL13]
  assign host_shared_lines_oe = s_reg.host_oe;
  assign host_shared_lines_out = s_reg.host_out;
  assign cc_byte_position = s_reg.mw[F_CCPOS]; // [RL14]
  assign bus_source_enables = s_reg.bus_en;
  assign constant_value = s_reg.const_val;
  assign input_sign_translate = s_reg.mw[F_SGNIN]; // [RL17]
  assign output_sign_translate = s_reg.mw[F_SGNOUT]; // [RL17]
  assign bcd_shift_source_select = s_reg.mw[F_BCD_SHIFT_SOURCE_SELECT +: 2]; // [RL17]
  assign decimal_operation_control = s_reg.mw[F_DECIMAL_OPERATION_CONTROL +: 2]; // [RL17]
  assign high_nibble_path_select = s_reg.mw[F_HNIB +: 2]; // [RL17]
  assign low_nibble_path_select = s_reg.mw[F_LNIB +: 2]; // [RL17]
  assign odd_address_latch_enables = s_reg.mw[F_ODD +: 4]; // [RL18]
  assign operation_enables = s_reg.op_en;
  assign host_microaddress = s_reg.host_ua;
  assign decimal_carry_to_bus = s_reg.mw[F_DCB]; // [RL21]
endmodule : mwfc_microword_control

// ---- sim/mwfc_properties.sv ----
`timescale 1ns/1ps
module mwfc_chk #(
  parameter int CS_DEPTH = 1000
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] internal_data_bus_in,
  input wire logic [15:0] host_shared_lines_out,
  input wire logic [3:0] a_side_register_select,
  input wire logic binary_carry_inject,
  input wire logic sp_write_high,
  input wire logic sp_write_low,
  input wire logic [7:0] bus_source_enables,
  input wire logic [6:0] operation_enables,
  input wire logic [15:0] constant_value,
  input wire logic [8:0] host_microaddress,
  input wire logic [9:0] microaddress
);
  import mwfc_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // a cycle without a read strobe
  sequence no_rd_s;
    !reg_rd;
  endsequence
  // first edge after reset release
  sequence rel_s;
    $rose(rst_b);
  endsequence
  reset_vals_a: assert property (rel_s |-> a_side_register_select == 4'hf && !binary_carry_inject
    && constant_value == 16'h0007 && host_microaddress == 9'h1e1 && microaddress == 10'h000)
    else $error("defaults missing after reset");
  rdata_idle_a: assert property (no_rd_s |=> reg_rdata == 32'h0)
    else $error("read data outside read answer");
  host_out_a: assert property ($past(rst_b) |-> host_shared_lines_out == $past(internal_data_bus_in))
    else $error("host output not previous bus value");
  bus_onehot_a: assert property ($onehot0(bus_source_enables))
    else $error("several bus sources enabled");
  op_onehot_a: assert property ($onehot0(operation_enables))
    else $error("several operation enables");
  hua_range_a: assert property (host_microaddress >= HUA_BASE && host_microaddress <= HUA_MAX)
    else $error("host microaddress out of range");
  sp_pair_a: assert property (sp_write_high |-> sp_write_low)
    else $error("high byte write without low byte");
  const_set_a: assert property (constant_value inside {[16'h0001:16'h0008]})
    else $error("constant outside table");
endmodule : mwfc_chk

bind mwfc_microword_control mwfc_chk #(.CS_DEPTH(CS_DEPTH)) i_chk (.sys_clk, .rst_b, .reg_rd, .reg_rdata,
  .internal_data_bus_in, .host_shared_lines_out, .a_side_register_select, .binary_carry_inject,
  .sp_write_high, .sp_write_low, .bus_source_enables, .operation_enables, .constant_value,
  .host_microaddress, .microaddress);

// ---- sim/mwfc_host_model.sv ----
`timescale 1ns/1ps
module mwfc_host_model (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [15:0] op,
  output logic [15:0] lines
);
  logic [14:0] cnt_reg = 15'h0;
  // host traffic never looks like an extended opcode outside a dispatch
  always @(posedge sys_clk) begin
    cnt_reg <= cnt_reg + 15'h1;
    lines <= go ? op : {1'b1, cnt_reg};
  end
endmodule : mwfc_host_model

// ---- sim/microword_field_control_test.sv ----
`timescale 1ns/1ps
module microword_field_control_test;
  import mwfc_pkg::*;
  logic sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, go = 0, pend = 0;
  logic [7:0] reg_addr = 8'h00, branch_array_in = 8'h20;
  logic [31:0] reg_wdata = 32'h0, e;
  logic [15:0] internal_data_bus_in = 16'h0, op = 16'h0, host_shared_lines_in;
  logic [3:0] cond_codes_in = 4'h4;
  logic [87:0] a, b, c;
  logic [9:0] k;
  int seed = 21, fails = 0, checks = 0;
  logic [31:0] exq[$];
  wire [31:0] reg_rdata;
  wire [15:0] host_shared_lines_out, constant_value;
  wire [9:0] microaddress;
  wire [8:0] host_microaddress;
  wire [7:0] bus_source_enables;
  wire [6:0] operation_enables;
  wire [3:0] a_side_register_select, b_side_register_select, odd_address_latch_enables;
  wire [2:0] binary_destination_select, binary_function_select, binary_operand_select;
  wire [1:0] shift_direction_control, byte_swap_control, bcd_shift_source_select;
  wire [1:0] decimal_operation_control, high_nibble_path_select, low_nibble_path_select;
  wire host_shared_lines_oe, coprocessor_mode_bit, sp_write_high, sp_write_low, binary_carry_inject;
  wire shift_fill_value, direct_input_source_select, input_mux_drive_enable, y_output_buffer_enable;
  wire cc_byte_position, input_sign_translate, output_sign_translate, decimal_carry_to_bus;
  wire [95:0] obs = {microaddress, a_side_register_select, b_side_register_select, binary_carry_inject,
    shift_fill_value, shift_direction_control, binary_destination_select, binary_function_select,
    binary_operand_select, direct_input_source_select, input_mux_drive_enable, byte_swap_control,
    y_output_buffer_enable, host_shared_lines_oe, cc_byte_position, input_sign_translate,
    output_sign_translate, bcd_shift_source_select, decimal_operation_control, high_nibble_path_select,
    low_nibble_path_select, odd_address_latch_enables, coprocessor_mode_bit, decimal_carry_to_bus,
    sp_write_high, sp_write_low, bus_source_enables, operation_enables, constant_value, host_microaddress};
  mwfc_microword_control #(.CS_DEPTH(128)) i_dut (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .host_shared_lines_in, .host_shared_lines_out, .host_shared_lines_oe,
    .internal_data_bus_in, .cond_codes_in, .branch_array_in, .microaddress, .coprocessor_mode_bit,
    .a_side_register_select, .b_side_register_select, .sp_write_high, .sp_write_low, .binary_carry_inject,
    .shift_fill_value, .shift_direction_control, .binary_destination_select, .binary_function_select,
    .binary_operand_select, .direct_input_source_select, .input_mux_drive_enable, .byte_swap_control,
    .y_output_buffer_enable, .cc_byte_position, .bus_source_enables, .constant_value, .input_sign_translate,
    .output_sign_translate, .bcd_shift_source_select, .decimal_operation_control, .high_nibble_path_select,
    .low_nibble_path_select, .odd_address_latch_enables, .operation_enables, .host_microaddress,
    .decimal_carry_to_bus);
  mwfc_host_model i_host (.sys_clk, .go, .op, .lines(host_shared_lines_in));
  // clock and random internal bus traffic
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) internal_data_bus_in <= 16'($random(seed));
  // expected outputs of a microword standing at address ua
  function automatic logic [95:0] expw(input logic [9:0] ua, input logic [87:0] w);
    logic [4:0] v;
    logic [9:0] h;
    v = w[20:16];
    h = 10'h1e0 + {4'h0, w[15:10]};
    expw = {ua, w[75:72], w[68:65], ~w[69], w[64:46], w[37:28], w[24:21], w[1:0], w[70], |w[71:70],
      (w[45:41] == 5'h0 || w[27:25] == 3'h0) ? 8'h0 : 8'h1 << w[27:25],
      (v == 5'h0 || v > 5'h7) ? 7'h0 : 7'h1 << (v - 5'h1),
      CONST_ROM[w[40:38]], h > 10'h1fe ? 9'h1fe : h[8:0]};
  endfunction : expw
  function automatic logic [87:0] rw();
    logic [95:0] t;
    t = {$random(seed), $random(seed), $random(seed)};
    return t[87:0];
  endfunction : rw
  task automatic chkw(input logic [9:0] ua, input logic [87:0] w);
    @(negedge sys_clk);
    checks++;
    if (obs !== expw(ua, w)) begin
      fails++;
      $display("Error %0t outputs %h at %h", $time, obs, ua);
    end
  endtask : chkw
  task automatic bus(input logic w, input logic r, input logic [7:0] ad, input logic [31:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge sys_clk);
  endtask : bus
  task automatic rd(input logic [7:0] ad, input logic [31:0] x);
    exq.push_back(x);
    bus(0, 1, ad, 32'h0);
  endtask : rd
  task automatic ld(input logic [9:0] i, input logic [87:0] w);
    bus(1, 0, REG_CS_INDEX, {22'h0, i});
    bus(1, 0, REG_CS_DATA0, w[31:0]);
    bus(1, 0, REG_CS_DATA1, w[63:32]);
    bus(1, 0, REG_CS_DATA2, {8'h0, w[87:64]});
    bus(0, 0, 8'h00, 32'h0);
  endtask : ld
  task automatic disp(input logic [15:0] x);
    go <= 1'b1;
    op <= x;
    @(posedge sys_clk);
    go <= 1'b0;
    // the design samples the opcode at this edge; the entry word stands until the next one
    @(posedge sys_clk);
  endtask : disp
  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  // read answers are compared against the oldest note
  initial forever begin
    @(negedge sys_clk);
    if (pend) begin
      checks++;
      e = exq.pop_front();
      if (reg_rdata !== e) begin
        fails++;
        $display("Error %0t read %h expected %h", $time, reg_rdata, e);
      end
    end
    pend = reg_rd;
  end
  initial begin
    #50000;
    fails++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    chkw(10'h000, MW_RESET);
    @(posedge sys_clk);
    ld(10'h000, MW_RESET);
    disp(16'h7c05);
    chkw(10'h000, MW_RESET);
    @(posedge sys_clk);
    bus(1, 0, REG_CTRL, 32'h1);
    bus(0, 0, 8'h00, 32'h0);
    rd(REG_STATUS, 32'h5);
    rd(REG_CTRL, 32'h1);
    rd(8'h20, 32'h0);
    bus(0, 0, 8'h00, 32'h0);
    for (int i = 0; i < 4; i++) begin
      k = 10'h060 + 10'($random(seed) & 31);
      a = rw();
      b = rw();
      c = rw();
      {a[87:76], a[9:1]} = {12'h010, 4'he, 4'h0, 1'b1};
      {b[87:76], b[9:1]} = {12'h000, 4'h0, 4'h1, 1'b1};
      {c[87:76], c[9:1]} = {12'h000, 8'h00, 1'b1};
      ld(k, a);
      ld(10'h017, b);
      ld(10'h020, c);
      rd(REG_CS_INDEX, 32'h21);
      rd(REG_CS_DATA0, c[31:0]);
      rd(REG_CS_DATA1, c[63:32]);
      bus(0, 0, 8'h00, 32'h0);
      disp(16'h7c40 | {10'h0, 6'(k - 10'h060)});
      chkw(10'h000, MW_RESET);
      @(posedge sys_clk);
      disp(16'h7c00 | {10'h0, 6'(k - 10'h060)});
      chkw(k, a);
      chkw(10'h017, b);
      chkw(10'h020, c);
      chkw(10'h000, MW_RESET);
      @(posedge sys_clk);
    end
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    chkw(10'h000, MW_RESET);
    close_out();
  end
endmodule : microword_field_control_test
